//--- common/cipl_pkg.sv
package cipl_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CIPL_OFS_STATUS   = 8'h00;
  localparam logic [7:0] CIPL_OFS_CORE     = 8'h04;
  localparam logic [7:0] CIPL_OFS_INTCTL   = 8'h08;
  localparam logic [7:0] CIPL_OFS_SRCPRI15 = 8'h0c;
  localparam logic [7:0] CIPL_OFS_REQ      = 8'h10;

  // Field positions
  localparam int CIPL_STATUS_LOW_LSB = 5;
  localparam int CIPL_CORE_HIGH_BIT  = 3;
  localparam int CIPL_NEST_DIS_BIT   = 15;
  localparam int CIPL_FAULT_PRI_LSB  = 12;
  localparam int CIPL_CLOCK_PRI_LSB  = 8;

  // Reset values
  localparam logic [2:0] CIPL_LOW_RST        = 3'h0;
  localparam logic       CIPL_HIGH_RST       = 1'b0;
  localparam logic       CIPL_NEST_DIS_RST   = 1'b0;
  localparam logic [2:0] CIPL_FAULT_PRI_RST  = 3'h4;
  localparam logic [2:0] CIPL_CLOCK_PRI_RST  = 3'h4;

  localparam logic [2:0] CIPL_LOW_ALL_MASKED = 3'h7;
  localparam logic [2:0] CIPL_PRI_DISABLED   = 3'h0;
  localparam int         CIPL_NUM_SRC        = 2;

  typedef enum logic [1:0] {
    CIPL_HTRANS_IDLE   = 2'h0,
    CIPL_HTRANS_BUSY   = 2'h1,
    CIPL_HTRANS_NONSEQ = 2'h2,
    CIPL_HTRANS_SEQ    = 2'h3
  } cipl_htrans_type;

endpackage

//--- design/cipl_bus_slave.sv
`timescale 1ns/10ps
`default_nettype none
module cipl_bus_slave
  import cipl_pkg::*;
(
  input  wire logic        hclk,       // System clock
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write not read
  input  wire logic [7:0]  haddr,      // Byte address, low bits
  input  wire logic        hready,     // Bus ready
  output logic             wr_en,      // Write strobe in data phase
  output logic             rd_en,      // Read strobe in data phase
  output logic [7:0]       acc_addr    // Latched address
);

  logic       wr_r;
  logic       wr_nxt;
  logic       rd_r;
  logic       rd_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       take;

  assign take = hsel && hready && (htrans == CIPL_HTRANS_NONSEQ
                                   || htrans == CIPL_HTRANS_SEQ);

  always_comb begin
    wr_nxt   = take && hwrite;
    rd_nxt   = take && !hwrite;
    addr_nxt = take ? haddr : addr_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign wr_en    = wr_r;
  assign rd_en    = rd_r;
  assign acc_addr = addr_r;

endmodule
`default_nettype wire

//--- design/cipl_src_gate.sv
`timescale 1ns/10ps
`default_nettype none
module cipl_src_gate
  import cipl_pkg::*;
(
  input  wire logic       hclk,     // System clock
  input  wire logic       hresetn,  // Async reset, active low
  input  wire logic       req_in,   // Raw source request
  input  wire logic [2:0] src_pri,  // Programmed source priority
  input  wire logic [3:0] cpu_lvl,  // Current four-bit cpu level
  output logic            req_out   // Gated request to core
);

  logic pass;

  // Code 000 can never exceed a level, so it disables the source too
  assign pass = req_in && (src_pri != CIPL_PRI_DISABLED)
                && ({1'b0, src_pri} > cpu_lvl);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_out <= 1'b0;
    end else begin
      req_out <= pass;
    end
  end

  chk_gate_follows : assert property (@(posedge hclk) disable iff (!hresetn)
    req_out == $past(req_in && src_pri != 3'h0 && {1'b0, src_pri} > cpu_lvl))
    else $error("Gated request does not follow priority compare");

endmodule
`default_nettype wire

//--- design/cipl_top.sv
// Behaviour
// - Status word bits 7..5 hold the low three cpu priority bits.
// - Low bits equal seven block every user interrupt.
// - Core control bit 3 sits above low bits forming a four-bit level.
// - High bit set keeps all user interrupts disabled.
// - Nesting disable set ignores software writes to low bits; core level loads still apply.
// - High bit reads one when level above seven, else zero.
// - Three-bit source priorities; 000 disables; fault 14..12, clock 10..8.
`timescale 1ns/10ps
`default_nettype none
module cipl_top
  import cipl_pkg::*;
(
  input  wire logic        hclk,          // System clock, 20 MHz
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write not read
  input  wire logic [2:0]  hsize,         // Transfer size, word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic             hreadyout,     // Slave ready out
  output logic             hresp,         // Always OKAY
  output logic [31:0]      hrdata,        // Read data
  input  wire logic        fault_req,     // Motor fault source request
  input  wire logic        clock_req,     // Clock calendar source request
  input  wire logic        core_lvl_we,   // Core writes a new level
  input  wire logic [3:0]  core_lvl_in,   // Level from core on accept
  output logic             fault_irq,     // Fault request to core
  output logic             clock_irq,     // Clock request to core
  output logic [3:0]       cpu_level,     // Current four-bit level
  output logic             user_irq_off   // All user interrupts masked
);

  ////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic       wr_en;
  logic       rd_en;
  logic [7:0] acc_addr;

  cipl_bus_slave u_bus (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .haddr    (haddr[7:0]),
    .hready   (hready),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .acc_addr (acc_addr)
  );

  // Zero wait states; every access completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Priority state

  logic [2:0] low_r;
  logic [2:0] low_nxt;
  logic       high_r;
  logic       high_nxt;
  logic       nest_dis_r;
  logic       nest_dis_nxt;
  logic [2:0] fault_pri_r;
  logic [2:0] fault_pri_nxt;
  logic [2:0] clock_pri_r;
  logic [2:0] clock_pri_nxt;

  logic wr_status;
  logic wr_core;
  logic wr_intcon;
  logic wr_srcpri;

  assign wr_status = wr_en && (acc_addr == CIPL_OFS_STATUS);
  assign wr_core   = wr_en && (acc_addr == CIPL_OFS_CORE);
  assign wr_intcon = wr_en && (acc_addr == CIPL_OFS_INTCTL);
  assign wr_srcpri = wr_en && (acc_addr == CIPL_OFS_SRCPRI15);

  always_comb begin
    low_nxt       = low_r;
    high_nxt      = high_r;
    nest_dis_nxt  = nest_dis_r;
    fault_pri_nxt = fault_pri_r;
    clock_pri_nxt = clock_pri_r;
    // Level written by the core on interrupt accept or return wins
    if (core_lvl_we) begin
      high_nxt = core_lvl_in[3];
      low_nxt  = core_lvl_in[2:0];
    end else begin
      // Software write to low bits blocked while nesting is off
      if (wr_status && !nest_dis_r) begin
        low_nxt = hwdata[CIPL_STATUS_LOW_LSB +: 3];
      end
      if (wr_core) begin
        high_nxt = hwdata[CIPL_CORE_HIGH_BIT];
      end
    end
    if (wr_intcon) begin
      nest_dis_nxt = hwdata[CIPL_NEST_DIS_BIT];
    end
    if (wr_srcpri) begin
      fault_pri_nxt = hwdata[CIPL_FAULT_PRI_LSB +: 3];
      clock_pri_nxt = hwdata[CIPL_CLOCK_PRI_LSB +: 3];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_r       <= CIPL_LOW_RST;
      high_r      <= CIPL_HIGH_RST;
      nest_dis_r  <= CIPL_NEST_DIS_RST;
      fault_pri_r <= CIPL_FAULT_PRI_RST;
      clock_pri_r <= CIPL_CLOCK_PRI_RST;
    end else begin
      low_r       <= low_nxt;
      high_r      <= high_nxt;
      nest_dis_r  <= nest_dis_nxt;
      fault_pri_r <= fault_pri_nxt;
      clock_pri_r <= clock_pri_nxt;
    end
  end

  assign cpu_level    = {high_r, low_r};
  // Either condition alone masks every user source
  assign user_irq_off = high_r || (low_r == CIPL_LOW_ALL_MASKED);

  ////////////////////////////////////////////////////////////////////////
  // Source gating

  logic [CIPL_NUM_SRC-1:0] raw_req;
  logic [CIPL_NUM_SRC-1:0] gated_req;
  logic [2:0]              src_pri [CIPL_NUM_SRC];

  assign raw_req    = {clock_req, fault_req};
  assign src_pri[0] = fault_pri_r;
  assign src_pri[1] = clock_pri_r;

  // Priorities top out at 7, so levels 7..15 block every source
  for (genvar i = 0; i < CIPL_NUM_SRC; i++) begin : g_src
    cipl_src_gate u_gate (
      .hclk    (hclk),
      .hresetn (hresetn),
      .req_in  (raw_req[i]),
      .src_pri (src_pri[i]),
      .cpu_lvl (cpu_level),
      .req_out (gated_req[i])
    );
  end

  assign fault_irq = gated_req[0];
  assign clock_irq = gated_req[1];

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Read mux sits on the address phase so data is ready in the data phase
  always_comb begin
    rdata_nxt = rdata_r;
    if (hsel && hready && htrans[1] && !hwrite) begin
      rdata_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
        CIPL_OFS_STATUS:   rdata_nxt[CIPL_STATUS_LOW_LSB +: 3] = low_nxt;
        CIPL_OFS_CORE:     rdata_nxt[CIPL_CORE_HIGH_BIT] = high_nxt;
        CIPL_OFS_INTCTL:   rdata_nxt[CIPL_NEST_DIS_BIT] = nest_dis_nxt;
        CIPL_OFS_SRCPRI15: begin
          rdata_nxt[CIPL_FAULT_PRI_LSB +: 3] = fault_pri_nxt;
          rdata_nxt[CIPL_CLOCK_PRI_LSB +: 3] = clock_pri_nxt;
        end
        CIPL_OFS_REQ:      rdata_nxt[1:0] = gated_req;
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_low_locked : assert property (@(posedge hclk) disable iff (!hresetn)
    (nest_dis_r && !core_lvl_we) |=> (low_r == $past(low_r)))
    else $error("Low level bits changed while nesting disabled");

  chk_nest_write : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_intcon |=> (nest_dis_r == $past(hwdata[15])))
    else $error("Nesting disable bit not loaded");

  chk_low_write : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_status && !nest_dis_r && !core_lvl_we) |=> (low_r == $past(hwdata[7:5])))
    else $error("Status write did not load low level bits");

  chk_low_hold : assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_status && !core_lvl_we) |=> (low_r == $past(low_r)))
    else $error("Low level bits changed without a write");

  chk_low_report : assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_en && acc_addr == CIPL_OFS_STATUS) |-> (hrdata[7:5] == low_r))
    else $error("Low level bits read back wrong");

  chk_high_mask : assert property (@(posedge hclk) disable iff (!hresetn)
    high_r |=> !fault_irq && !clock_irq)
    else $error("Request passed while high level bit set");

  chk_level_high : assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_level > 4'h7) |-> user_irq_off)
    else $error("User interrupts open above level seven");

  chk_seven_mask : assert property (@(posedge hclk) disable iff (!hresetn)
    (low_r == 3'h7) |-> ##1 (!fault_irq && !clock_irq))
    else $error("Request passed at level seven");

  chk_user_mask : assert property (@(posedge hclk) disable iff (!hresetn)
    user_irq_off == (cpu_level >= 4'h7))
    else $error("User mask flag disagrees with level");

  chk_level_join : assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_level == {high_r, low_r} && (cpu_level > 4'h7) == high_r)
    else $error("Four-bit level badly formed");

  chk_high_write : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_core && !core_lvl_we) |=> (high_r == $past(hwdata[3])))
    else $error("Core control write did not load high bit");

  chk_high_hold : assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_core && !core_lvl_we) |=> (high_r == $past(high_r)))
    else $error("High bit changed without a write");

  chk_core_load : assert property (@(posedge hclk) disable iff (!hresetn)
    core_lvl_we |=> (cpu_level == $past(core_lvl_in)))
    else $error("Level loaded by core not taken");

  chk_high_report : assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_en && acc_addr == CIPL_OFS_CORE) |-> (hrdata[3] == (cpu_level > 4'h7)))
    else $error("High bit read back wrong");

  chk_pri_field : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_srcpri |=> (fault_pri_r == $past(hwdata[14:12])
                   && clock_pri_r == $past(hwdata[10:8])))
    else $error("Source priority fields not loaded");

  chk_pri_hold : assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_srcpri |=> (fault_pri_r == $past(fault_pri_r)
                    && clock_pri_r == $past(clock_pri_r)))
    else $error("Source priority changed without a write");

  chk_pri_report : assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_en && acc_addr == CIPL_OFS_SRCPRI15)
    |-> (hrdata[14:12] == fault_pri_r && hrdata[10:8] == clock_pri_r))
    else $error("Source priority fields read back wrong");

  chk_disabled_src : assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_pri_r == 3'h0) |=> !fault_irq)
    else $error("Disabled fault source passed");

  chk_clock_off : assert property (@(posedge hclk) disable iff (!hresetn)
    (clock_pri_r == 3'h0) |=> !clock_irq)
    else $error("Disabled clock source passed");

  chk_pass_fault : assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_req && {1'b0, fault_pri_r} > cpu_level) |=> fault_irq)
    else $error("Eligible fault request was dropped");

  chk_pass_clock : assert property (@(posedge hclk) disable iff (!hresetn)
    (clock_req && {1'b0, clock_pri_r} > cpu_level) |=> clock_irq)
    else $error("Eligible clock request was dropped");

  chk_fault_held : assert property (@(posedge hclk) disable iff (!hresetn)
    (!fault_req || {1'b0, fault_pri_r} <= cpu_level) |=> !fault_irq)
    else $error("Fault request passed without exceeding level");

  chk_clock_held : assert property (@(posedge hclk) disable iff (!hresetn)
    (!clock_req || {1'b0, clock_pri_r} <= cpu_level) |=> !clock_irq)
    else $error("Clock request passed without exceeding level");

  chk_req_report : assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_en && acc_addr == CIPL_OFS_REQ) |-> (hrdata[1:0] == $past(gated_req)))
    else $error("Gated requests read back wrong");

  ////////////////////////////////////////////////////////////////////////
  // Coverage

  cov_nest_block : cover property (@(posedge hclk) disable iff (!hresetn)
    wr_status && nest_dis_r);
  cov_fault_pass : cover property (@(posedge hclk) disable iff (!hresetn)
    fault_irq);
  cov_clock_pass : cover property (@(posedge hclk) disable iff (!hresetn)
    clock_irq && cpu_level != 4'h0);
  cov_high_set : cover property (@(posedge hclk) disable iff (!hresetn)
    high_r && clock_req);
  cov_core_load : cover property (@(posedge hclk) disable iff (!hresetn)
    core_lvl_we && core_lvl_in > 4'h7);

endmodule
`default_nettype wire

//--- verif/cipl_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module cipl_core_model (
  input  wire logic       hclk,         // System clock
  input  wire logic       hresetn,      // Async reset, active low
  input  wire logic [1:0] src_on,       // Raise requests {clock, fault}
  input  wire logic       lvl_cmd_we,   // Core told to load a level
  input  wire logic [3:0] lvl_cmd,      // Level to load
  output logic            fault_req,    // Motor fault request
  output logic            clock_req,    // Clock calendar request
  output logic            core_lvl_we,  // Level load strobe
  output logic [3:0]      core_lvl_in   // Level value, junk when idle
);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {clock_req, fault_req} <= 2'h0;
      core_lvl_we            <= 1'b0;
      core_lvl_in            <= 4'h0;
    end else begin
      {clock_req, fault_req} <= src_on;
      core_lvl_we            <= lvl_cmd_we;
      // Scrambled when idle, so a stale level never passes for a load
      core_lvl_in            <= lvl_cmd_we ? lvl_cmd : ~core_lvl_in;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cipl_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lvl_we = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, src_on = 2'h0;
  logic [3:0]  lvl = 4'h0, cpu_level, core_lvl_in;
  logic        hreadyout, hresp, fault_irq, clock_irq, user_irq_off;
  logic        fault_req, clock_req, core_lvl_we;
  int          fails = 0;
  int          n_checks = 0;

  always #25 hclk = ~hclk;

  cipl_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_req(fault_req),
    .clock_req(clock_req), .core_lvl_we(core_lvl_we), .core_lvl_in(core_lvl_in),
    .fault_irq(fault_irq), .clock_irq(clock_irq), .cpu_level(cpu_level),
    .user_irq_off(user_irq_off));

  cipl_core_model core_u (.hclk(hclk), .hresetn(hresetn), .src_on(src_on),
    .lvl_cmd_we(lvl_we), .lvl_cmd(lvl), .fault_req(fault_req), .clock_req(clock_req),
    .core_lvl_we(core_lvl_we), .core_lvl_in(core_lvl_in));

  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task hwait;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: bus hang", $time);
      summarize();
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= CIPL_HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hwait();
    hsel   <= 1'b0;
    htrans <= CIPL_HTRANS_IDLE;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    xfer(1'b0, a, 32'h0);
    chk(rd & mask, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Level, mask flag and gated requests after a change has settled
  task look(input logic [3:0] l, input logic off, input logic [1:0] irqs);
    repeat (3) @(posedge hclk);
    #1;
    chk({25'h0, user_irq_off, clock_irq, fault_irq, cpu_level}, {25'h0, off, irqs, l});
    @(posedge hclk);
  endtask

  task load(input logic [3:0] l);
    lvl    <= l;
    lvl_we <= 1'b1;
    @(posedge hclk);
    lvl_we <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(CIPL_OFS_STATUS, 32'h0, 32'he0);
    rchk(CIPL_OFS_CORE, 32'h0, 32'h8);
    rchk(CIPL_OFS_INTCTL, 32'h0, 32'h8000);
    rchk(CIPL_OFS_SRCPRI15, 32'h4400, 32'h7700);
    src_on <= 2'h3;
    for (int v = 0; v < 8; v++) begin
      xfer(1'b1, CIPL_OFS_STATUS, v << 5);
      rchk(CIPL_OFS_STATUS, v << 5, 32'he0);
      look(v[3:0], v == 7, {2{v < 4}});
    end
    xfer(1'b1, CIPL_OFS_STATUS, 32'h60);
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, CIPL_OFS_SRCPRI15, (p << 12) | ((7 - p) << 8));
      rchk(CIPL_OFS_SRCPRI15, (p << 12) | ((7 - p) << 8), 32'h7700);
      look(4'h3, 1'b0, {(7 - p) > 3, p > 3});
    end
    xfer(1'b1, CIPL_OFS_CORE, 32'h8);
    look(4'hb, 1'b1, 2'h0);
    rchk(CIPL_OFS_CORE, 32'h8, 32'h8);
    load(4'h5);
    look(4'h5, 1'b0, 2'h1);
    rchk(CIPL_OFS_REQ, 32'h1, 32'h3);
    rchk(CIPL_OFS_CORE, 32'h0, 32'h8);
    rchk(CIPL_OFS_STATUS, 32'ha0, 32'he0);
    xfer(1'b1, CIPL_OFS_INTCTL, 32'h8000);
    rchk(CIPL_OFS_INTCTL, 32'h8000, 32'h8000);
    xfer(1'b1, CIPL_OFS_STATUS, 32'h0);
    rchk(CIPL_OFS_STATUS, 32'ha0, 32'he0);
    xfer(1'b1, CIPL_OFS_INTCTL, 32'h0);
    xfer(1'b1, CIPL_OFS_STATUS, 32'h20);
    rchk(CIPL_OFS_STATUS, 32'h20, 32'he0);
    look(4'h1, 1'b0, 2'h1);
    xfer(1'b1, 8'h20, 32'hffffffff);
    rchk(8'h20, 32'h0, 32'hffffffff);
    load(4'hf);
    look(4'hf, 1'b1, 2'h0);
    rchk(CIPL_OFS_CORE, 32'h8, 32'h8);
    // Mid-run reset must bring back the power-on level and priorities
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(CIPL_OFS_CORE, 32'h0, 32'h8);
    rchk(CIPL_OFS_SRCPRI15, 32'h4400, 32'h7700);
    look(4'h0, 1'b0, 2'h3);
    summarize();
  end
endmodule
`default_nettype wire
